// ===== upstream_contention_tx_fsm.sv
// Overview of operation
// - Idle clears exponent and attempts, waits for a packet, computes wait, defers.
// - Exponent is clamped to MAP floor and ceiling; wait drawn below two^exponent.
// - The random source returns a value from zero to n minus one.
// - While deferring, a grant to our own flow is handled by do_grant.
// - While deferring, a unicast request slot gets a request, stamp, grant pending.
// - Each contention slot decrements a nonzero wait; send only at zero.
// - Wait zero, big request/data slot: send packet; piggyback selects next wait state.
// - Wait zero, slot too small: send request in contention, stamp, grant pending.
// - A MAP with no usable slot keeps the wait count and stays deferring.
// - Data-ack pending returns to idle when the MAP acknowledges our flow.
// - Ack time past stamp without ack: idle if MAP was lost, else retry.
// - Grant pending uses every own grant; ack time past stamp means retry.
// - Grant fits packet: send whole, stamp; grant pending if piggyback else idle.
// - Grant below minimum piece but above a request: send request, grant pending.
// - A zero-size own grant leaves grant pending without transmitting.
// - Fragments are first, middle, last; remaining size shrinks; then grant pending.
// - Fragment piggyback omitted if another own grant remains, else sized to remainder.
// - Retry increments attempts; above sixteen drop, flag exception, return idle.
// - Otherwise exponent rises by one, wait recomputed, deferring again.
// - Missed-schedule flag is set when a MAP is lost in data-ack pending.
// - Piggyback flag is set when a piggyback request rides along a transmission.
// - Fit comparisons use packet length with overhead plus any piggyback request; fragment size uses the remainder alone.
module upstream_contention_tx_fsm (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic queue_empty,
  input wire logic [15:0] pkt_len,
  input wire logic [15:0] piggy_len,
  input wire logic [13:0] own_flow_id,
  input wire logic [31:0] cur_time,
  input wire logic map_start,
  input wire logic [3:0] map_floor,
  input wire logic [3:0] map_ceil,
  input wire logic [31:0] map_ack_time,
  input wire logic [7:0] map_own_grants,
  input wire logic map_end,
  input wire logic map_lost,
  input wire logic ent_valid,
  input wire contention_pkg::ent_e ent_kind,
  input wire logic [13:0] ent_flow,
  input wire logic [15:0] ent_size,
  output logic tx_valid,
  output contention_pkg::txk_e tx_kind,
  output contention_pkg::piece_e tx_piece,
  output logic [15:0] tx_len,
  output logic [15:0] tx_piggy_len,
  output logic [31:0] tx_stamp,
  output logic pkt_release,
  output logic drop_exception,
  output contention_pkg::st_e fsm_state,
  output logic [4:0] attempts
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    contention_pkg::st_e st;
    logic [3:0] exp;
    logic [4:0] tries;
    logic [15:0] wait_cnt;
    logic [31:0] stamp;
    logic [3:0] floor;
    logic [3:0] ceil;
    logic [31:0] ack_time;
    logic ack_hit;
    logic lost;
    logic piggy;
    logic [15:0] rem;
    contention_pkg::piece_e piece;
    logic [7:0] grants_left;
    logic [15:0] lfsr;
    logic tx_valid;
    contention_pkg::txk_e tx_kind;
    contention_pkg::piece_e tx_piece;
    logic [15:0] tx_len;
    logic [15:0] tx_piggy_len;
    logic release_p;
    logic drop;
  } state_s;

  state_s q_ff;
  state_s nxt_q;

  // Clamp the exponent, then mask the random word: result is {exponent, wait}
  function automatic logic [19:0] compute_wait(input logic [3:0] e, input logic [3:0] fl,
                                               input logic [3:0] ce, input logic [15:0] r);
    logic [3:0] w;
    logic [16:0] m;
    w = e;
    if (w < fl)
      w = fl;
    if (w > ce)
      w = ce;
    // Masking with two^w minus one yields 0 .. two^w - 1
    m = (17'h00001 << w) - 17'h00001;
    return {w, r & m[15:0]};
  endfunction

  // ==========================================================================
  // Next state
  // ==========================================================================
  logic own;
  logic do_grant;
  logic do_retry;
  logic [15:0] need;
  logic [15:0] frag;
  logic [15:0] left;
  logic [19:0] cw;

  always_comb
  begin
    nxt_q = q_ff;
    nxt_q.lfsr = {q_ff.lfsr[14:0], q_ff.lfsr[15] ^ q_ff.lfsr[13] ^ q_ff.lfsr[12] ^ q_ff.lfsr[10]};
    nxt_q.tx_valid = 1'b0;
    nxt_q.release_p = 1'b0;
    nxt_q.drop = 1'b0;
    do_grant = 1'b0;
    do_retry = 1'b0;
    frag = 16'h0000;
    left = 16'h0000;
    cw = 20'h00000;
    own = ent_valid && (ent_flow == own_flow_id);
    // Packet length as sent, with the piggyback request it would carry
    need = q_ff.rem + piggy_len;
    if (map_start)
    begin
      nxt_q.floor = map_floor;
      nxt_q.ceil = map_ceil;
      nxt_q.ack_time = map_ack_time;
      nxt_q.ack_hit = 1'b0;
      nxt_q.grants_left = map_own_grants;
    end
    if (map_lost && q_ff.st == contention_pkg::ST_ACK_PEND)
      nxt_q.lost = 1'b1;
    if (own && ent_kind == contention_pkg::EK_GRANT && q_ff.grants_left != 8'h00)
      nxt_q.grants_left = q_ff.grants_left - 8'h01;
    if (own && ent_kind == contention_pkg::EK_DATA_ACK)
      nxt_q.ack_hit = 1'b1;
    unique case (q_ff.st)
      contention_pkg::ST_IDLE:
      begin
        nxt_q.exp = contention_pkg::EXP_RST;
        nxt_q.tries = contention_pkg::TRIES_RST;
        nxt_q.piggy = 1'b0;
        nxt_q.lost = 1'b0;
        if (!queue_empty)
        begin
          cw = compute_wait(contention_pkg::EXP_RST, q_ff.floor, q_ff.ceil, q_ff.lfsr);
          nxt_q.exp = cw[19:16];
          nxt_q.wait_cnt = cw[15:0];
          nxt_q.rem = pkt_len;
          nxt_q.piece = contention_pkg::PC_FULL;
          nxt_q.st = contention_pkg::ST_DEFER;
        end
      end
      contention_pkg::ST_DEFER:
      begin
        if (own && ent_kind == contention_pkg::EK_GRANT)
          do_grant = 1'b1;
        else if (own && ent_kind == contention_pkg::EK_UREQ)
        begin
          nxt_q.tx_valid = 1'b1;
          nxt_q.tx_kind = contention_pkg::TX_REQ_RES;
          nxt_q.tx_len = contention_pkg::REQ_SIZE;
          nxt_q.tx_piggy_len = 16'h0000;
          nxt_q.stamp = cur_time;
          nxt_q.st = contention_pkg::ST_GRANT_PEND;
        end
        else if (ent_valid && (ent_kind == contention_pkg::EK_REQ_OP ||
                               ent_kind == contention_pkg::EK_REQDATA_OP))
        begin
          if (q_ff.wait_cnt != 16'h0000)
            nxt_q.wait_cnt = q_ff.wait_cnt - 16'h0001;
          else if (ent_kind == contention_pkg::EK_REQDATA_OP && ent_size >= need)
          begin
            nxt_q.tx_valid = 1'b1;
            nxt_q.tx_kind = contention_pkg::TX_DATA_CONT;
            nxt_q.tx_piece = contention_pkg::PC_FULL;
            nxt_q.tx_len = need;
            nxt_q.tx_piggy_len = piggy_len;
            nxt_q.piggy = piggy_len != 16'h0000;
            nxt_q.stamp = cur_time;
            nxt_q.st = (piggy_len != 16'h0000) ? contention_pkg::ST_GRANT_PEND
                                                : contention_pkg::ST_ACK_PEND;
            nxt_q.lost = 1'b0;
          end
          else
          begin
            nxt_q.tx_valid = 1'b1;
            nxt_q.tx_kind = contention_pkg::TX_REQ_CONT;
            nxt_q.tx_len = contention_pkg::REQ_SIZE;
            nxt_q.tx_piggy_len = 16'h0000;
            nxt_q.stamp = cur_time;
            nxt_q.st = contention_pkg::ST_GRANT_PEND;
          end
        end
        // Wait count simply carries over to the next MAP
      end
      contention_pkg::ST_GRANT_PEND:
      begin
        if (own && ent_kind == contention_pkg::EK_GRANT)
          do_grant = 1'b1;
        if (map_end && q_ff.ack_time > q_ff.stamp)
          do_retry = 1'b1;
      end
      contention_pkg::ST_ACK_PEND:
      begin
        if (map_end)
        begin
          if (q_ff.ack_hit)
          begin
            nxt_q.st = contention_pkg::ST_IDLE;
            nxt_q.release_p = 1'b1;
          end
          else if (q_ff.ack_time > q_ff.stamp)
          begin
            // A lost MAP may have held our ack; resending risks a duplicate
            if (q_ff.lost)
            begin
              nxt_q.st = contention_pkg::ST_IDLE;
              nxt_q.release_p = 1'b1;
            end
            else
              do_retry = 1'b1;
          end
        end
      end
    endcase

    if (do_grant)
    begin
      if (q_ff.piece == contention_pkg::PC_FULL && ent_size >= need)
      begin
        nxt_q.tx_valid = 1'b1;
        nxt_q.tx_kind = contention_pkg::TX_DATA_RES;
        nxt_q.tx_piece = contention_pkg::PC_FULL;
        nxt_q.tx_len = need;
        nxt_q.tx_piggy_len = piggy_len;
        nxt_q.piggy = piggy_len != 16'h0000;
        nxt_q.stamp = cur_time;
        nxt_q.st = (piggy_len != 16'h0000) ? contention_pkg::ST_GRANT_PEND
                                            : contention_pkg::ST_IDLE;
        nxt_q.release_p = piggy_len == 16'h0000;
      end
      else if (ent_size < contention_pkg::MIN_FRAG && ent_size > contention_pkg::REQ_SIZE)
      begin
        nxt_q.tx_valid = 1'b1;
        nxt_q.tx_kind = contention_pkg::TX_REQ_RES;
        nxt_q.tx_len = contention_pkg::REQ_SIZE;
        nxt_q.tx_piggy_len = 16'h0000;
        nxt_q.stamp = cur_time;
        nxt_q.st = contention_pkg::ST_GRANT_PEND;
      end
      else if (ent_size == 16'h0000)
        nxt_q.st = contention_pkg::ST_GRANT_PEND;
      else
      begin
        frag = (ent_size < q_ff.rem) ? ent_size : q_ff.rem;
        left = q_ff.rem - frag;
        nxt_q.rem = left;
        nxt_q.piece = (q_ff.piece == contention_pkg::PC_FULL) ? contention_pkg::PC_FIRST
                                                              : contention_pkg::PC_MIDDLE;
        if (left == 16'h0000)
          nxt_q.piece = contention_pkg::PC_LAST;
        nxt_q.tx_valid = 1'b1;
        nxt_q.tx_kind = contention_pkg::TX_DATA_RES;
        nxt_q.tx_piece = nxt_q.piece;
        nxt_q.tx_len = frag;
        // A later grant in this MAP makes a request pointless
        nxt_q.tx_piggy_len = (q_ff.grants_left > 8'h01) ? 16'h0000 : left;
        nxt_q.piggy = nxt_q.tx_piggy_len != 16'h0000;
        nxt_q.stamp = cur_time;
        nxt_q.st = contention_pkg::ST_GRANT_PEND;
      end
    end

    if (do_retry)
    begin
      nxt_q.tries = q_ff.tries + 5'h01;
      if (q_ff.tries + 5'h01 > contention_pkg::MAX_TRIES)
      begin
        nxt_q.drop = 1'b1;
        nxt_q.release_p = 1'b1;
        nxt_q.st = contention_pkg::ST_IDLE;
      end
      else
      begin
        nxt_q.exp = (q_ff.exp == contention_pkg::EXP_MAX) ? q_ff.exp
                                                          : q_ff.exp + 4'h1;
        cw = compute_wait(nxt_q.exp, q_ff.floor, q_ff.ceil, q_ff.lfsr);
        nxt_q.exp = cw[19:16];
        nxt_q.wait_cnt = cw[15:0];
        nxt_q.st = contention_pkg::ST_DEFER;
      end
    end
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      q_ff <= '0;
      q_ff.lfsr <= contention_pkg::LFSR_SEED;
    end
    else
      q_ff <= nxt_q;
  end

  assign tx_valid = q_ff.tx_valid;
  assign tx_kind = q_ff.tx_kind;
  assign tx_piece = q_ff.tx_piece;
  assign tx_len = q_ff.tx_len;
  assign tx_piggy_len = q_ff.tx_piggy_len;
  assign tx_stamp = q_ff.stamp;
  assign pkt_release = q_ff.release_p;
  assign drop_exception = q_ff.drop;
  assign fsm_state = q_ff.st;
  assign attempts = q_ff.tries;

  // ==========================================================================
  // Checks
  // ==========================================================================
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence own_zero_grant_s;
    q_ff.st == contention_pkg::ST_GRANT_PEND && own &&
      ent_kind == contention_pkg::EK_GRANT && ent_size == 16'h0000;
  endsequence

  sequence defer_skip_s;
    q_ff.st == contention_pkg::ST_DEFER && !own && ent_valid &&
      ent_kind == contention_pkg::EK_REQ_OP && q_ff.wait_cnt != 16'h0000;
  endsequence

  idle_cleared_a: assert property (
    q_ff.st == contention_pkg::ST_IDLE && !queue_empty |=>
      q_ff.st == contention_pkg::ST_DEFER && q_ff.tries == 5'h00)
    else $error("idle did not start deferring with zero attempts");
  wait_bound_a: assert property (
    q_ff.st == contention_pkg::ST_DEFER |-> {1'b0, q_ff.wait_cnt} < (17'h00001 << q_ff.exp))
    else $error("wait count not below two to the exponent");
  defer_count_a: assert property (
    defer_skip_s |=> q_ff.wait_cnt == $past(q_ff.wait_cnt) - 16'h0001 && !q_ff.tx_valid)
    else $error("contention slot not skipped with decrement");
  cont_tx_zero_a: assert property (
    q_ff.tx_valid && q_ff.tx_kind == contention_pkg::TX_DATA_CONT |-> $past(q_ff.wait_cnt) == 16'h0000)
    else $error("contention transmit with nonzero wait");
  ack_to_idle_a: assert property (
    q_ff.st == contention_pkg::ST_ACK_PEND && map_end && q_ff.ack_hit |=>
      q_ff.st == contention_pkg::ST_IDLE ##1 q_ff.tries == 5'h00)
    else $error("acknowledged data did not return to idle");
  zero_grant_a: assert property (
    own_zero_grant_s |=> q_ff.st == contention_pkg::ST_GRANT_PEND && !q_ff.tx_valid)
    else $error("zero grant caused a transmission");
  last_piece_a: assert property (
    q_ff.tx_valid && q_ff.tx_piece == contention_pkg::PC_LAST |-> q_ff.rem == 16'h0000)
    else $error("last piece with data remaining");
  drop_idle_a: assert property (
    q_ff.drop |-> q_ff.st == contention_pkg::ST_IDLE && q_ff.tries == 5'h11 && q_ff.release_p)
    else $error("drop without seventeen attempts or idle");
  lost_flag_a: assert property (
    q_ff.st == contention_pkg::ST_ACK_PEND && map_lost |=> q_ff.lost)
    else $error("missed-schedule flag not set");
  piggy_flag_a: assert property (
    q_ff.tx_valid && q_ff.tx_piggy_len != 16'h0000 |-> q_ff.piggy)
    else $error("piggyback sent without flag");

endmodule // upstream_contention_tx_fsm

// ===== contention_pkg.sv
package contention_pkg;

  // ==========================================================================
  // Widths
  // ==========================================================================
  localparam int SIZE_W = 16;
  localparam int TIME_W = 32;
  localparam int EXP_W = 4;
  localparam int TRIES_W = 5;
  localparam int FLOW_W = 14;
  localparam int GCNT_W = 8;

  // ==========================================================================
  // Sizes, limits and reset values
  // ==========================================================================
  // Length of a bandwidth request burst, overhead included
  localparam logic [15:0] REQ_SIZE = 16'h0010;
  // Smallest fragment the flow may send
  localparam logic [15:0] MIN_FRAG = 16'h0040;
  localparam logic [4:0] MAX_TRIES = 5'h10;
  localparam logic [3:0] EXP_MAX = 4'hF;
  localparam logic [3:0] EXP_RST = 4'h0;
  localparam logic [4:0] TRIES_RST = 5'h00;
  localparam logic [15:0] LFSR_SEED = 16'hACE1;

  // ==========================================================================
  // Enumerations
  // ==========================================================================
  typedef enum logic [1:0] {ST_IDLE, ST_DEFER, ST_GRANT_PEND, ST_ACK_PEND} st_e;
  typedef enum logic [1:0] {PC_FULL, PC_FIRST, PC_MIDDLE, PC_LAST} piece_e;
  typedef enum logic [1:0] {TX_REQ_CONT, TX_DATA_CONT, TX_REQ_RES, TX_DATA_RES} txk_e;
  typedef enum logic [2:0] {EK_GRANT, EK_UREQ, EK_REQ_OP, EK_REQDATA_OP, EK_DATA_ACK} ent_e;

endpackage

// ===== head_end_model.sv
module head_end_model (
  input wire logic clk_sys,
  output logic map_start,
  output logic [3:0] map_floor,
  output logic [3:0] map_ceil,
  output logic [31:0] map_ack_time,
  output logic [7:0] map_own_grants,
  output logic map_end,
  output logic map_lost,
  output logic ent_valid,
  output contention_pkg::ent_e ent_kind,
  output logic [13:0] ent_flow,
  output logic [15:0] ent_size
);
  timeunit 1ns;
  timeprecision 100ps;

  // Idle cycles before each event, so the scheduler can also answer slowly
  int slack;

  initial
  begin
    slack = 0;
    {map_start, ent_valid, map_end, map_lost} = 4'h0;
    {map_floor, map_ceil, map_own_grants} = 16'h0000;
    map_ack_time = 32'h00000000;
    ent_kind = contention_pkg::EK_GRANT;
    ent_flow = 14'h0000;
    ent_size = 16'h0000;
  end

  // ==========================================================================
  // MAP events
  // ==========================================================================
  task automatic lead();
    repeat (slack) @(posedge clk_sys);
    @(posedge clk_sys);
  endtask

  // Flow, size and ack time are inverted once the strobe drops; kind, floor, ceiling and grant count are left as they were
  task automatic drop();
    @(posedge clk_sys);
    {map_start, ent_valid, map_end, map_lost} <= 4'h0;
    ent_flow <= ~ent_flow;
    ent_size <= ~ent_size;
    map_ack_time <= ~map_ack_time;
  endtask

  task automatic map_begin(input logic [3:0] fl, input logic [3:0] ce, input logic [31:0] ack,
                           input logic [7:0] own);
    lead();
    map_start <= 1'b1;
    map_floor <= fl;
    map_ceil <= ce;
    map_ack_time <= ack;
    map_own_grants <= own;
    drop();
  endtask

  task automatic entry(input contention_pkg::ent_e k, input logic [13:0] f, input logic [15:0] s);
    lead();
    ent_valid <= 1'b1;
    ent_kind <= k;
    ent_flow <= f;
    ent_size <= s;
    drop();
  endtask

  task automatic ends(input logic e, input logic l);
    lead();
    map_end <= e;
    map_lost <= l;
    drop();
  endtask
endmodule // head_end_model

// ===== testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  localparam contention_pkg::st_e s_idle = contention_pkg::ST_IDLE;
  localparam contention_pkg::st_e s_def = contention_pkg::ST_DEFER;
  localparam contention_pkg::st_e s_gp = contention_pkg::ST_GRANT_PEND;
  localparam contention_pkg::st_e s_ap = contention_pkg::ST_ACK_PEND;
  localparam logic [13:0] own = 14'h0123;
  localparam logic [13:0] oth = 14'h0456;
  localparam logic [15:0] nop = 16'hFFFF;
  logic clk_sys, rst, queue_empty, map_start, map_end, map_lost, ent_valid, hit;
  logic [15:0] pkt_len, piggy_len, ent_size, tx_len, tx_piggy_len;
  logic [13:0] ent_flow;
  logic [31:0] cur_time, map_ack_time, tx_stamp;
  logic [3:0] map_floor, map_ceil;
  logic [7:0] map_own_grants;
  logic tx_valid, pkt_release, drop_exception;
  logic [4:0] attempts;
  contention_pkg::ent_e ent_kind;
  contention_pkg::txk_e tx_kind;
  contention_pkg::piece_e tx_piece;
  contention_pkg::st_e fsm_state;
  int n_errors, num_checks, cycles;

  head_end_model u_head (
    .clk_sys, .map_start, .map_floor, .map_ceil, .map_ack_time, .map_own_grants, .map_end,
    .map_lost, .ent_valid, .ent_kind, .ent_flow, .ent_size
  );

  upstream_contention_tx_fsm u_dut (
    .clk_sys, .rst, .queue_empty, .pkt_len, .piggy_len, .own_flow_id(own), .cur_time,
    .map_start, .map_floor, .map_ceil, .map_ack_time, .map_own_grants, .map_end, .map_lost,
    .ent_valid, .ent_kind, .ent_flow, .ent_size, .tx_valid, .tx_kind, .tx_piece, .tx_len,
    .tx_piggy_len, .tx_stamp, .pkt_release, .drop_exception, .fsm_state, .attempts
  );

  always #12.5 clk_sys = ~clk_sys;

  // ==========================================================================
  // Checking and closing
  // ==========================================================================
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // A whole run is well under a thousand cycles
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      n_errors++;
      final_report();
    end
  end

  // ==========================================================================
  // Access tasks
  // ==========================================================================
  task automatic map(input logic [3:0] w, input logic [31:0] ack, input logic [7:0] g);
    u_head.map_begin(w, w, ack, g);
    #1;
  endtask

  task automatic op(input contention_pkg::ent_e k, input logic [13:0] f, input logic [15:0] s);
    u_head.entry(k, f, s);
    #1;
  endtask

  task automatic close(input logic e, input logic l);
    u_head.ends(e, l);
    #1;
  endtask

  task automatic txc(input contention_pkg::txk_e k, input logic [15:0] pg,
                     input contention_pkg::st_e st);
    chk(tx_valid, 1'b1);
    chk(tx_kind, k);
    if (pg !== nop)
      chk(tx_piggy_len, pg);
    chk(tx_stamp, cur_time);
    chk(fsm_state, st);
  endtask

  task automatic quiet(input contention_pkg::st_e st);
    chk(tx_valid, 1'b0);
    chk(fsm_state, st);
  endtask

  // The queue is shown non-empty for one cycle only: the block latches the head
  task automatic start_pkt(input logic [15:0] len, input logic [15:0] pg);
    @(posedge clk_sys);
    pkt_len <= len;
    piggy_len <= pg;
    queue_empty <= 1'b0;
    cur_time <= cur_time + 32'h00000100;
    @(posedge clk_sys);
    queue_empty <= 1'b1;
    #1;
    chk(fsm_state, s_def);
    chk(attempts, 5'h00);
  endtask

  task automatic reset_dut();
    @(posedge clk_sys);
    rst <= 1'b1;
    @(posedge clk_sys);
    rst <= 1'b0;
    #1;
    chk(fsm_state, s_idle);
    chk(attempts, 5'h00);
  endtask

  task automatic to_ack();
    map(4'h0, 32'h00000000, 8'h00);
    op(contention_pkg::EK_REQDATA_OP, oth, pkt_len);
    txc(contention_pkg::TX_DATA_CONT, 16'h0000, s_ap);
    close(1'b1, 1'b0);
  endtask

  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial
  begin
    {clk_sys, rst, queue_empty} = 3'b011;
    pkt_len = 16'h0000;
    piggy_len = 16'h0000;
    cur_time = 32'h00000000;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    #1;
    quiet(s_idle);
    start_pkt(16'h0100, 16'h0000);
    map(4'h0, 32'h00000000, 8'h00);
    op(contention_pkg::EK_REQ_OP, oth, 16'h0008);
    txc(contention_pkg::TX_REQ_CONT, nop, s_gp);
    close(1'b1, 1'b0);
    map(4'h0, 32'h00000000, 8'h01);
    op(contention_pkg::EK_GRANT, oth, 16'h0100);
    quiet(s_gp);
    op(contention_pkg::EK_GRANT, own, 16'h0100);
    txc(contention_pkg::TX_DATA_RES, 16'h0000, s_idle);
    chk(tx_piece, contention_pkg::PC_FULL);
    chk(pkt_release, 1'b1);
    close(1'b1, 1'b0);
    start_pkt(16'h0040, 16'h0000);
    map(4'h0, 32'h00000000, 8'h00);
    op(contention_pkg::EK_UREQ, own, 16'h0010);
    txc(contention_pkg::TX_REQ_RES, nop, s_gp);
    close(1'b1, 1'b0);
    map(4'h0, 32'h00000000, 8'h03);
    op(contention_pkg::EK_GRANT, own, 16'h0000);
    quiet(s_gp);
    op(contention_pkg::EK_GRANT, own, 16'h0020);
    txc(contention_pkg::TX_REQ_RES, nop, s_gp);
    op(contention_pkg::EK_GRANT, own, 16'h0040);
    txc(contention_pkg::TX_DATA_RES, 16'h0000, s_idle);
    close(1'b1, 1'b0);
    // Piggyback length counts toward the size that must fit
    start_pkt(16'h0080, 16'h0010);
    map(4'h0, 32'h00000000, 8'h00);
    op(contention_pkg::EK_REQDATA_OP, oth, 16'h0080);
    txc(contention_pkg::TX_REQ_CONT, nop, s_gp);
    close(1'b1, 1'b0);
    map(4'h0, cur_time + 32'h00000001, 8'h00);
    close(1'b1, 1'b0);
    chk(attempts, 5'h01);
    chk(fsm_state, s_def);
    map(4'h0, 32'h00000000, 8'h00);
    op(contention_pkg::EK_REQDATA_OP, oth, 16'h0090);
    txc(contention_pkg::TX_DATA_CONT, 16'h0010, s_gp);
    close(1'b1, 1'b0);
    map(4'h0, 32'h00000000, 8'h01);
    op(contention_pkg::EK_GRANT, own, 16'h0090);
    txc(contention_pkg::TX_DATA_RES, 16'h0010, s_gp);
    close(1'b1, 1'b0);
    reset_dut();
    // An own acknowledgement wins over an expired ack time
    start_pkt(16'h0080, 16'h0000);
    to_ack();
    map(4'h0, cur_time + 32'h00000001, 8'h00);
    op(contention_pkg::EK_DATA_ACK, oth, 16'h0000);
    quiet(s_ap);
    op(contention_pkg::EK_DATA_ACK, own, 16'h0000);
    close(1'b1, 1'b0);
    chk(fsm_state, s_idle);
    start_pkt(16'h0080, 16'h0000);
    to_ack();
    close(1'b0, 1'b1);
    map(4'h0, cur_time + 32'h00000001, 8'h00);
    close(1'b1, 1'b0);
    chk(fsm_state, s_idle);
    chk(drop_exception, 1'b0);
    start_pkt(16'h0080, 16'h0000);
    for (int i = 1; i <= 17; i++)
    begin
      to_ack();
      map(4'h0, cur_time + 32'h00000001, 8'h00);
      close(1'b1, 1'b0);
      if (i < 17)
      begin
        chk(attempts, i[4:0]);
        chk(fsm_state, s_def);
      end
      else
      begin
        chk(drop_exception, 1'b1);
        chk(pkt_release, 1'b1);
        chk(fsm_state, s_idle);
      end
    end
    start_pkt(16'h0100, 16'h0000);
    map(4'h0, 32'h00000000, 8'h01);
    op(contention_pkg::EK_GRANT, own, 16'h0080);
    txc(contention_pkg::TX_DATA_RES, 16'h0080, s_gp);
    chk(tx_piece, contention_pkg::PC_FIRST);
    chk(tx_len, 16'h0080);
    close(1'b1, 1'b0);
    map(4'h0, 32'h00000000, 8'h02);
    op(contention_pkg::EK_GRANT, own, 16'h0040);
    txc(contention_pkg::TX_DATA_RES, 16'h0000, s_gp);
    chk(tx_piece, contention_pkg::PC_MIDDLE);
    op(contention_pkg::EK_GRANT, own, 16'h0040);
    txc(contention_pkg::TX_DATA_RES, 16'h0000, s_gp);
    chk(tx_piece, contention_pkg::PC_LAST);
    close(1'b1, 1'b0);
    reset_dut();
    // Slow scheduler; a window of four must expire within sixteen slots
    u_head.slack = 2;
    // The window must be in effect before the wait is drawn, or the wait is zero
    map(4'h4, 32'h00000000, 8'h00);
    close(1'b1, 1'b0);
    start_pkt(16'h0080, 16'h0000);
    map(4'h4, 32'h00000000, 8'h00);
    close(1'b1, 1'b0);
    chk(fsm_state, s_def);
    map(4'h4, 32'h00000000, 8'h00);
    hit = 1'b0;
    for (int i = 0; i < 16 && !hit; i++)
    begin
      op(contention_pkg::EK_REQ_OP, oth, 16'h0008);
      hit = tx_valid;
    end
    chk(hit, 1'b1);
    chk(fsm_state, s_gp);
    close(1'b1, 1'b0);
    final_report();
  end
endmodule // testbench
